// ==== design/scpwm_pkg.sv ====
// package for the single channel pwm: sfr map, fields, reset values, carriers
package scpwm_pkg;
  localparam logic [7:0] SCPWM_ADDR_CONTROL = 8'ha9;
  localparam logic [7:0] SCPWM_ADDR_DUTY    = 8'haa;
  localparam logic [7:0] SCPWM_RST_CONTROL  = 8'h00;
  localparam logic [7:0] SCPWM_RST_DUTY     = 8'h00;
  localparam int         SCPWM_MODE_MSB     = 7;
  localparam int         SCPWM_MODE_LSB     = 6;
  localparam int         SCPWM_PRESC_MSB    = 5;
  localparam int         SCPWM_PRESC_LSB    = 0;
  localparam logic [7:0] SCPWM_TOP_6BIT     = 8'h3f;
  localparam logic [7:0] SCPWM_TOP_7BIT     = 8'h7f;
  localparam logic [7:0] SCPWM_TOP_8BIT     = 8'hff;
  localparam logic [7:0] SCPWM_MASK_6BIT    = 8'h3f;
  localparam logic [7:0] SCPWM_MASK_7BIT    = 8'h7f;
  localparam logic [7:0] SCPWM_MASK_8BIT    = 8'hff;

  typedef enum logic [1:0] {
    SCPWM_OFF,
    SCPWM_P6,
    SCPWM_P7,
    SCPWM_P8
  } scpwm_mode_t;

  // one sfr access from the cpu core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scpwm_sfr_req_t;
endpackage : scpwm_pkg

// ==== design/scpwm_top.sv ====
// single channel pwm with control and duty special function registers
// Overview of operation
// - mode field 00 keeps the modulator idle with the output held low.
// - mode 01 wraps the period counter after 63 steps and uses duty bits 5:0.
// - mode 10 wraps the period counter after 127 steps and uses duty bits 6:0.
// - mode 11 wraps the period counter after 255 steps and uses all duty bits.
// - each step lasts control bits 5:0 plus one clock cycles.
// - a duty write acts on the output at once, not at the period end.
// - duty bits above the selected period width are ignored.
// - control sits at sfr 0xa9 and duty at 0xaa, both read/write and reset to zero.
// - period length is counted in cycles of the oscillator clock.
`timescale 1ns/1ps
module scpwm_top
  import scpwm_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // sfr access
  input  wire scpwm_pkg::scpwm_sfr_req_t sfr_req,
  output logic                    [7:0]  sfr_rdata,
  // pwm pin
  output logic                           pwm_out
);
  import scpwm_pkg::*;

  // stored registers and their next values
  logic [7:0]  control_r;
  logic [7:0]  control_nxt;
  logic [7:0]  duty_r;
  logic [7:0]  duty_nxt;
  logic [5:0]  presc_r;
  logic [5:0]  presc_nxt;
  logic [7:0]  period_r;
  logic [7:0]  period_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        out_r;
  logic        out_nxt;

  // sfr decode
  logic        sel_control;
  logic        sel_duty;
  logic        sfr_hit;
  logic        wr_control;
  logic        wr_duty;

  // control fields and mode decode
  scpwm_mode_t mode;
  logic [5:0]  presc_top;
  logic        enabled;
  logic        is_p6;
  logic        is_p7;

  // period and duty limits
  logic [7:0]  period_top;
  logic [7:0]  period_last;
  logic [7:0]  duty_mask;
  logic [7:0]  duty_eff;

  // prescaler and period counter steering
  logic        step;
  logic        presc_clear;
  logic [5:0]  presc_inc;
  logic        period_wrap;
  logic        period_over;
  logic        period_restart;
  logic        period_advance;
  logic [7:0]  period_inc;

  // pin compare
  logic        below_duty;

  // reads have no side effect, so the read qualifier is not needed
  assign sel_control = (sfr_req.addr == SCPWM_ADDR_CONTROL);
  assign sel_duty    = (sfr_req.addr == SCPWM_ADDR_DUTY);
  assign sfr_hit     = sel_control || sel_duty;
  // a write needs the strobe and a matching address
  assign wr_control  = sfr_req.wr && sel_control;
  assign wr_duty     = sfr_req.wr && sel_duty;

  // whole bytes are stored; duty bits above the period width are kept for read-back
  assign control_nxt = wr_control ? sfr_req.wdata : control_r;
  assign duty_nxt    = wr_duty ? sfr_req.wdata : duty_r;

  // control fields
  assign mode        = scpwm_mode_t'(control_r[SCPWM_MODE_MSB:SCPWM_MODE_LSB]);
  assign presc_top   = control_r[SCPWM_PRESC_MSB:SCPWM_PRESC_LSB];
  // modes 01 and 10 narrow the period; 11 and the idle code fall through to 8 bits
  assign is_p6       = (mode == SCPWM_P6);
  assign is_p7       = (mode == SCPWM_P7);
  // field 00 idles the modulator; leaving it starts both counters from zero
  assign enabled     = (mode != SCPWM_OFF);

  assign period_top  = is_p6 ? SCPWM_TOP_6BIT :
                       is_p7 ? SCPWM_TOP_7BIT :
                               SCPWM_TOP_8BIT;
  // counter runs 0..top-1, so one period is exactly top steps
  assign period_last = period_top - 8'h01;

  // duty width follows the period width
  assign duty_mask   = is_p6 ? SCPWM_MASK_6BIT :
                       is_p7 ? SCPWM_MASK_7BIT :
                               SCPWM_MASK_8BIT;
  // live duty, no shadow copy: a write reaches the compare one clock later
  assign duty_eff    = duty_r & duty_mask;

  // one step every presc+1 oscillator clocks
  // lowering the prescale mid-step ends the step at once instead of wrapping through 63
  assign step        = (presc_r >= presc_top);
  // step and counter restart share one clock so both stay in line
  assign presc_clear = !enabled || step;
  assign presc_inc   = presc_r + 6'h01;
  assign presc_nxt   = presc_clear ? 6'h00 : presc_inc;

  assign period_wrap    = (period_r == period_last);
  // a switch to a shorter period may leave the count above the new top: restart at once
  assign period_over    = (period_r > period_last);
  assign period_restart = !enabled || period_over || (step && period_wrap);
  assign period_advance = step && !period_wrap;
  assign period_inc     = period_r + 8'h01;
  assign period_nxt     = period_restart ? 8'h00 :
                          period_advance ? period_inc :
                                           period_r;

  // compare with the count the counter is about to hold, so pin and counter agree
  assign below_duty  = (period_nxt < duty_eff);
  assign out_nxt     = enabled && below_duty;

  // read data shows whole bytes, zero for any other address
  assign rdata_nxt   = !sfr_hit    ? 8'h00 :
                       sel_control ? control_r :
                                     duty_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      control_r <= SCPWM_RST_CONTROL;
    end
    else
    begin
      control_r <= control_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      duty_r <= SCPWM_RST_DUTY;
    end
    else
    begin
      duty_r <= duty_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      presc_r <= 6'h00;
    end
    else
    begin
      presc_r <= presc_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      period_r <= 8'h00;
    end
    else
    begin
      period_r <= period_nxt;
    end
  end

  // pin register
  // registered so decode changes never glitch the pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_r <= 1'b0;
    end
    else
    begin
      out_r <= out_nxt;
    end
  end

  // read data register
  // a write and a read in one clock return the byte before the write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // outputs come straight from their flip-flops
  assign pwm_out   = out_r;
  assign sfr_rdata = rdata_r;
endmodule : scpwm_top

// ==== sim/scpwm_load.sv ====
// load model on the pwm pin: measures period and high time
`timescale 1ns/1ps
module scpwm_load
(
  // clock
  input  wire logic clk,
  // pwm pin seen by the load
  input  wire logic pin,
  // last full period and its high time, in clocks
  output int        hi,
  output int        per
);
  int   h_r = 0, p_r = 0;
  logic q_r = 1'b0;
  always @(posedge clk)
  begin
    q_r <= pin;
    p_r <= pin && !q_r ? 1 : p_r + 1;
    h_r <= pin && !q_r ? 1 : h_r + pin;
    if (pin && !q_r) {hi, per} <= {h_r, p_r};
  end
endmodule : scpwm_load

// ==== sim/scpwm_asserts.sv ====
// pwm checker
`timescale 1ns/1ps
module scpwm_asserts
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // sfr access
  input  wire scpwm_pkg::scpwm_sfr_req_t sfr_req,
  input  wire logic                [7:0] sfr_rdata,
  // pwm pin
  input  wire logic                      pwm_out
);
  logic [7:0] c_r, d_r;
  // shadow copies of the two registers, k is the top of the selected period
  wire  [7:0] a = sfr_req.addr, q = sfr_rdata, k = {&c_r[7:6], c_r[7], 6'h3f}, md = d_r & k;
  always_ff @(posedge clk or posedge rst)
    if (rst) {c_r, d_r} <= 16'h0000;
    else if (sfr_req.wr) {c_r, d_r} <= {a == 8'ha9 ? sfr_req.wdata : c_r, a == 8'haa ? sfr_req.wdata : d_r};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence set_d(v); sfr_req.wr && a == 8'haa && c_r > 8'h3f ##1 md == v; endsequence
  a_rd_ctl: assert property (a == 8'ha9 |=> q == $past(c_r)) else $error("read");
  a_rd_duty: assert property (a == 8'haa |=> q == $past(d_r)) else $error("read");
  a_rd_none: assert property (!(a inside {8'ha9, 8'haa}) |=> q == 8'h00) else $error("read");
  a_off_low: assert property (c_r < 8'h40 && $past(c_r) < 8'h40 |-> !pwm_out) else $error("off");
  a_zero_low: assert property ((md == 8'h00)[*3] |-> !pwm_out) else $error("zero");
  a_top_high: assert property ((c_r > 8'h3f && md == k)[*3] |-> pwm_out) else $error("top");
  a_now_low: assert property (set_d(8'h00) |-> ##[1:2] !pwm_out) else $error("late");
  a_now_high: assert property (set_d(k) |-> ##[1:2] pwm_out) else $error("late");
endmodule : scpwm_asserts
bind scpwm_top scpwm_asserts CHK (.clk, .rst, .sfr_req, .sfr_rdata, .pwm_out);

// ==== sim/test_scpwm_top.sv ====
// pwm bench
`timescale 1ns/1ps
module test_scpwm_top;
  logic                      clk = 0, rst = 1, pwm_out;
  scpwm_pkg::scpwm_sfr_req_t sfr_req = '0;
  logic [7:0]                sfr_rdata, c, d;
  int                        hi, per, fails = 0, num_checks = 0, cyc = 0;
  scpwm_top DUT (.clk, .rst, .sfr_req, .sfr_rdata, .pwm_out);
  scpwm_load LOAD (.clk, .pin(pwm_out), .hi, .per);
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (++cyc == 30000) tally_and_finish(1);
  // clocks spent on the masked value v under control m
  function int mult(logic [7:0] m, v);
    return int'(v & {&m[7:6], m[7], 6'h3f}) * (m[5:0] + 1);
  endfunction : mult
  task chk(string n, logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) $display("wrong value %s expected %0d seen %0d", n, exp, seen);
    fails += seen !== exp;
  endtask : chk
  task wr(logic [7:0] a, w);
    @(negedge clk) sfr_req = {2'b10, a, w};
    @(negedge clk) sfr_req.wr = 1'b0;
  endtask : wr
  // read data stands one clock after the address
  task rd(logic [7:0] a, exp);
    @(negedge clk) sfr_req.addr = a;
    @(negedge clk) chk("read data", sfr_rdata, exp);
  endtask : rd
  task tally_and_finish(int f);
    fails += f;
    $display("%0d checks, %0d fails", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    void'($urandom(11));
    repeat (10) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 3; i++) rd(8'ha9 + 8'(i), 8'h00);
    for (int i = 1; i < 7; i++)
    begin
      c = {2'(i % 3 + 1), 6'($urandom % 4)};
      // random upper bits, masked duty kept inside 1..top-1
      d = 8'($urandom) & 8'hdf | 8'h01;
      wr(8'ha9, 8'h00);
      wr(8'haa, d);
      wr(8'ha9, c);
      rd(8'ha9, c);
      rd(8'haa, d);
      repeat (3 * mult(c, 8'hff)) @(negedge clk);
      chk("period", per, mult(c, 8'hff));
      chk("high time", hi, mult(c, d));
      wr(8'haa, 8'hff);
      @(negedge clk) chk("duty jump high", pwm_out, 1'b1);
      wr(8'haa, 8'h00);
      @(negedge clk) chk("duty jump low", pwm_out, 1'b0);
      wr(8'haa, 8'hff);
      wr(8'ha9, 8'h00);
      @(negedge clk) chk("off level", pwm_out, 1'b0);
      wr(8'haa, 8'h00);
      $display("test %0d done", i);
    end
    tally_and_finish(0);
  end
endmodule : test_scpwm_top
